// ==== common/flash_prot_pkg.sv ====
/*
  Shared constants for the flash program/erase protection block: register
  byte offsets, bit positions, reset values, event and cause indices and the
  operating-mode enumeration.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package flash_prot_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_MODE_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_ERR_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_ERASE_SEL = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_MODE_STATE = 5'h14;

  // flash_mode_ctrl_one fields
  localparam int BIT_PROG_START = 0;
  localparam int BIT_ERASE_START = 1;
  localparam int BIT_WRITE_CHECK = 2;
  localparam int BIT_WASH_CHECK = 3;
  localparam int BIT_SW_WRITE_EN = 6;
  localparam logic [7:0] MODE_CTRL_USED = 8'h4f;
  localparam logic [7:0] MODE_CTRL_RST = 8'h00;

  // flash_error_status_reg fields: fault flag and latched cause
  localparam int BIT_FAULT = 7;
  localparam int NUM_CAUSE = 3;
  localparam int CAUSE_READ = 0;
  localparam int CAUSE_EXCEPT = 1;
  localparam int CAUSE_SLEEP = 2;
  localparam logic [NUM_CAUSE-1:0] CAUSE_RST = 3'h0;

  localparam logic [7:0] ERASE_SEL_RST = 8'h00;

  // Interrupt events
  localparam int NUM_EVT = 3;
  localparam int EVT_FAULT = 0;
  localparam int EVT_HW_ABORT = 1;
  localparam int EVT_REFUSED = 2;
  localparam logic [NUM_EVT-1:0] EVT_RST = 3'h0;

  // Mode state register bits
  localparam int ST_PROGRAM = 0;
  localparam int ST_ERASE = 1;
  localparam int ST_WRITE_CHECK = 2;
  localparam int ST_WASH_CHECK = 3;
  localparam int ST_ERR_PROT = 4;
  localparam int ST_INHIBIT = 5;

  typedef enum logic [2:0] {
    MODE_IDLE,
    MODE_PROGRAM,
    MODE_ERASE,
    MODE_WRITE_CHECK,
    MODE_WASH_CHECK
  } flash_mode_e;

endpackage : flash_prot_pkg

// ==== hdl/flash_fault_detect.sv ====
/*
  Algorithm-violation detector: flags a flash read, exception start or sleep
  instruction seen while program or erase mode is active, and latches the
  fault flag and first cause until reset or a hardware-protection clear.
  Assumes all inputs are synchronous single-clock-domain levels.
*/
`timescale 1ns/100ps
`default_nettype none

module flash_fault_detect
  import flash_prot_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Qualifiers
  input wire logic op_active_i,
  input wire logic clear_i,
  // Violation sources
  input wire logic flash_read_hit_i,
  input wire logic exception_start_i,
  input wire logic sleep_exec_i,
  // Results
  output logic err_o,
  output logic fault_o,
  output logic [NUM_CAUSE-1:0] cause_o
);

  logic [NUM_CAUSE-1:0] hit;
  logic fault_ff;
  logic [NUM_CAUSE-1:0] cause_ff;

  always_comb begin
    hit = '0;
    hit[CAUSE_READ] = flash_read_hit_i;
    hit[CAUSE_EXCEPT] = exception_start_i;
    hit[CAUSE_SLEEP] = sleep_exec_i;
  end

  // Only a live program or erase counts; a clearing cycle never faults
  assign err_o = op_active_i && !clear_i && (|hit);

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      fault_ff <= 1'b0;
    end else if (clear_i) begin
      fault_ff <= 1'b0;
    end else if (err_o) begin
      fault_ff <= 1'b1;
    end
  end

  // Keep only the first cause so software sees what tripped the lock
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      cause_ff <= CAUSE_RST;
    end else if (clear_i) begin
      cause_ff <= CAUSE_RST;
    end else if (err_o && !fault_ff) begin
      cause_ff <= hit;
    end
  end

  assign fault_o = fault_ff;
  assign cause_o = cause_ff;

endmodule : flash_fault_detect

`default_nettype wire

// ==== hdl/prot_irq_unit.sv ====
/*
  Sticky interrupt status with write-one-to-clear, a mask register and one
  level interrupt output, held off while interrupts are inhibited.
  Assumes one-cycle event pulses and one-cycle write strobes.
*/
`timescale 1ns/100ps
`default_nettype none

module prot_irq_unit #(
  parameter int NUM = 3
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Events and software access
  input wire logic [NUM-1:0] evt_i,
  input wire logic clr_wr_i,
  input wire logic mask_wr_i,
  input wire logic [NUM-1:0] wdata_i,
  input wire logic inhibit_i,
  // State
  output logic [NUM-1:0] status_o,
  output logic [NUM-1:0] mask_o,
  output logic irq_o
);

  logic [NUM-1:0] status_ff;
  logic [NUM-1:0] mask_ff;

  generate
    if (NUM < 1) begin : g_bad
      $error("prot_irq_unit needs at least one event");
    end
    for (genvar i = 0; i < NUM; i++) begin : g_bit
      // A new event in the clearing cycle keeps the bit set
      always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
          status_ff[i] <= 1'b0;
        end else if (evt_i[i]) begin
          status_ff[i] <= 1'b1;
        end else if (clr_wr_i && wdata_i[i]) begin
          status_ff[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      mask_ff <= '0;
    end else if (mask_wr_i) begin
      mask_ff <= wdata_i;
    end
  end

  assign status_o = status_ff;
  assign mask_o = mask_ff;
  assign irq_o = (|(status_ff & mask_ff)) && !inhibit_i;

endmodule : prot_irq_unit

`default_nettype wire

// ==== hdl/flash_prot_ctrl.sv ====
/*
  Flash program/erase protection controller: mode control, error status and
  erase block select registers on Avalon-MM, mode selection with hardware,
  software and error protection, interrupt inhibit and a protection IRQ.
  Assumes CPU-side event inputs are synchronous pulses or levels on clock_i
  and that reset_i follows the external clear pin after oscillator settling.
*/
// Overview of operation
// - All interrupts, NMI too, are held off during program/erase or boot.
// - Reset, subsleep or standby forcibly stops any program or erase.
// - Those transitions return mode, error and block registers to reset.
// - Cleared software write enable protects every flash block.
// - Under software protection, start bits never enter program or erase.
// - Each block select bit enables one block; zero protects all.
// - A detected violation sets the fault flag and locks error protection.
// - Reading flash while programming or erasing is a violation.
// - Any non-reset exception starting mid operation is a violation.
// - Sleep instruction during program or erase is a violation.
// - Error keeps register contents but stops program or erase at once.
// - In error protection, start bits cannot re-enter program or erase.
// - In error protection, verify bits still select verify modes.
// - Error protection and its flag persist until reset, subsleep or standby; writes can't clear.
// - Mode control selects program, program-verify, erase or erase-verify.
`timescale 1ns/100ps
`default_nettype none

module flash_prot_ctrl
  import flash_prot_pkg::*;
#(
  parameter int NUM_BLOCKS = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [DATA_W-1:0] avs_writedata_i,
  input wire logic [BE_W-1:0] avs_byteenable_i,
  output logic [DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Power-mode and CPU activity
  input wire logic subsleep_i,
  input wire logic standby_i,
  input wire logic boot_running_i,
  input wire logic flash_read_hit_i,
  input wire logic exception_start_i,
  input wire logic sleep_exec_i,
  // Flash array control
  output logic program_mode_o,
  output logic erase_mode_o,
  output logic write_check_mode_o,
  output logic wash_check_mode_o,
  output logic [NUM_BLOCKS-1:0] erase_block_en_o,
  // System
  output logic intr_inhibit_o,
  output logic flash_fault_flag_o,
  output logic irq_o
);

  generate
    if (NUM_BLOCKS < 1 || NUM_BLOCKS > 8) begin : g_bad_blocks
      $error("NUM_BLOCKS must be 1 to 8");
    end
  endgenerate

  logic ack_ff;
  logic req;
  logic wr_en;
  logic [7:0] wbyte;
  logic [DATA_W-1:0] readdata_ff;
  logic [DATA_W-1:0] nxt_readdata;

  logic [7:0] mode_ctrl_ff;
  logic [NUM_BLOCKS-1:0] erase_sel_ff;
  flash_mode_e state_ff;
  flash_mode_e nxt_state;

  logic hw_prot;
  logic op_active;
  logic err;
  logic fault;
  logic [NUM_CAUSE-1:0] cause;
  logic software_write_enable;
  logic start_req;
  logic refused;
  logic [NUM_EVT-1:0] evt;
  logic [NUM_EVT-1:0] irq_status;
  logic [NUM_EVT-1:0] irq_mask;
  logic [7:0] mode_state;
  logic [7:0] err_status;

  // Bus: one wait state per access; data is prepared in the wait cycle
  assign req = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = req && !ack_ff;
  assign wr_en = avs_write_i && ack_ff && avs_byteenable_i[0];
  assign wbyte = avs_writedata_i[7:0];

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req && !ack_ff;
    end
  end

  // Hardware protection is a level: held as long as the low-power request
  assign hw_prot = subsleep_i || standby_i;
  assign software_write_enable = mode_ctrl_ff[BIT_SW_WRITE_EN];
  assign op_active = (state_ff == MODE_PROGRAM) || (state_ff == MODE_ERASE);

  // Mode control register; low-power entry overrides any write
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      mode_ctrl_ff <= MODE_CTRL_RST;
    end else if (hw_prot) begin
      mode_ctrl_ff <= MODE_CTRL_RST;
    end else if (wr_en && avs_address_i == OFS_MODE_CTRL) begin
      // Bits are kept on error; only the mode itself is cut
      mode_ctrl_ff <= wbyte & MODE_CTRL_USED;
    end
  end

  // Erase block select register
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      erase_sel_ff <= ERASE_SEL_RST[NUM_BLOCKS-1:0];
    end else if (hw_prot) begin
      erase_sel_ff <= ERASE_SEL_RST[NUM_BLOCKS-1:0];
    end else if (wr_en && avs_address_i == OFS_ERASE_SEL) begin
      erase_sel_ff <= wbyte[NUM_BLOCKS-1:0];
    end
  end

  // Mode selection; priority program, erase, then the verify modes
  always_comb begin
    nxt_state = MODE_IDLE;
    if (hw_prot || err) begin
      nxt_state = MODE_IDLE;
    end else if (software_write_enable) begin
      if (mode_ctrl_ff[BIT_PROG_START] && !fault) begin
        nxt_state = MODE_PROGRAM;
      end else if (mode_ctrl_ff[BIT_ERASE_START] && !fault) begin
        nxt_state = MODE_ERASE;
      end else if (mode_ctrl_ff[BIT_WRITE_CHECK]) begin
        nxt_state = MODE_WRITE_CHECK;
      end else if (mode_ctrl_ff[BIT_WASH_CHECK]) begin
        nxt_state = MODE_WASH_CHECK;
      end
    end
  end

  // Error protection keeps fault set, so a restart after an error is
  // blocked even though the start bit still reads back as written
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state_ff <= MODE_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_comb begin
    program_mode_o = 1'b0;
    erase_mode_o = 1'b0;
    write_check_mode_o = 1'b0;
    wash_check_mode_o = 1'b0;
    unique case (state_ff)
      MODE_IDLE: begin
      end
      MODE_PROGRAM: begin
        program_mode_o = 1'b1;
      end
      MODE_ERASE: begin
        erase_mode_o = 1'b1;
      end
      MODE_WRITE_CHECK: begin
        write_check_mode_o = 1'b1;
      end
      MODE_WASH_CHECK: begin
        wash_check_mode_o = 1'b1;
      end
      default: begin
      end
    endcase
  end

  // Only selected blocks see the erase; an empty select erases nothing.
  // Several selected bits are passed as written; software keeps to one.
  assign erase_block_en_o = erase_mode_o ? erase_sel_ff : '0;

  // Interrupts are held off during program/erase and during boot
  assign intr_inhibit_o = op_active || boot_running_i;

  flash_fault_detect u_fault (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .op_active_i(op_active),
    .clear_i(hw_prot),
    .flash_read_hit_i(flash_read_hit_i),
    .exception_start_i(exception_start_i),
    .sleep_exec_i(sleep_exec_i),
    .err_o(err),
    .fault_o(fault),
    .cause_o(cause)
  );

  assign flash_fault_flag_o = fault;

  // A start written while protected is refused; flag it for software
  assign start_req = wr_en && avs_address_i == OFS_MODE_CTRL &&
    (wbyte[BIT_PROG_START] || wbyte[BIT_ERASE_START]);
  assign refused = start_req &&
    (!wbyte[BIT_SW_WRITE_EN] || fault || hw_prot);

  always_comb begin
    evt = EVT_RST;
    evt[EVT_FAULT] = err;
    evt[EVT_HW_ABORT] = hw_prot && (op_active ||
      mode_ctrl_ff[BIT_PROG_START] || mode_ctrl_ff[BIT_ERASE_START]);
    evt[EVT_REFUSED] = refused;
  end

  prot_irq_unit #(
    .NUM(NUM_EVT)
  ) u_irq (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .evt_i(evt),
    .clr_wr_i(wr_en && avs_address_i == OFS_IRQ_STATUS),
    .mask_wr_i(wr_en && avs_address_i == OFS_IRQ_MASK),
    .wdata_i(wbyte[NUM_EVT-1:0]),
    .inhibit_i(intr_inhibit_o),
    .status_o(irq_status),
    .mask_o(irq_mask),
    .irq_o(irq_o)
  );

  // Status images; writes to the error status are ignored
  always_comb begin
    err_status = 8'h00;
    err_status[BIT_FAULT] = fault;
    err_status[NUM_CAUSE-1:0] = cause;
    mode_state = 8'h00;
    mode_state[ST_PROGRAM] = program_mode_o;
    mode_state[ST_ERASE] = erase_mode_o;
    mode_state[ST_WRITE_CHECK] = write_check_mode_o;
    mode_state[ST_WASH_CHECK] = wash_check_mode_o;
    mode_state[ST_ERR_PROT] = fault;
    mode_state[ST_INHIBIT] = intr_inhibit_o;
  end

  always_comb begin
    nxt_readdata = '0;
    unique case (avs_address_i)
      OFS_MODE_CTRL: nxt_readdata[7:0] = mode_ctrl_ff;
      OFS_ERR_STATUS: nxt_readdata[7:0] = err_status;
      OFS_ERASE_SEL: nxt_readdata[NUM_BLOCKS-1:0] = erase_sel_ff;
      OFS_IRQ_STATUS: nxt_readdata[NUM_EVT-1:0] = irq_status;
      OFS_IRQ_MASK: nxt_readdata[NUM_EVT-1:0] = irq_mask;
      OFS_MODE_STATE: nxt_readdata[7:0] = mode_state;
      default: nxt_readdata = '0;
    endcase
  end

  // Read data is sampled in the wait cycle and held for the answer edge
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      readdata_ff <= '0;
    end else if (avs_read_i && !ack_ff) begin
      readdata_ff <= nxt_readdata;
    end
  end

  assign avs_readdata_o = readdata_ff;

endmodule : flash_prot_ctrl

`default_nettype wire

// ==== tb/flash_prot_checker.sv ====
/* Concurrent checks on the protection controller's ports, bound below.
   Assumes one clock domain and an asynchronous active-high reset. */
`timescale 1ns/100ps
`default_nettype none
module flash_prot_checker
  import flash_prot_pkg::*;
#(
  parameter int NUM_BLOCKS = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // CPU side
  input wire logic subsleep_i,
  input wire logic standby_i,
  input wire logic boot_running_i,
  input wire logic flash_read_hit_i,
  input wire logic exception_start_i,
  input wire logic sleep_exec_i,
  // Flash side and system
  input wire logic program_mode_o,
  input wire logic erase_mode_o,
  input wire logic [NUM_BLOCKS-1:0] erase_block_en_o,
  input wire logic intr_inhibit_o,
  input wire logic flash_fault_flag_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  logic pe;
  logic hw;
  assign pe = program_mode_o | erase_mode_o;
  assign hw = subsleep_i | standby_i;
  sequence s_busy_with(x);
    pe && !hw && x;
  endsequence
  sequence s_locked;
    flash_fault_flag_o && !pe;
  endsequence
  a_read_locks: assert property (
    s_busy_with(flash_read_hit_i) |=> s_locked)
    else $error("read during program or erase did not lock");
  a_except_locks: assert property (
    s_busy_with(exception_start_i) |=> s_locked)
    else $error("exception during program or erase did not lock");
  a_sleep_locks: assert property (
    s_busy_with(sleep_exec_i) |=> s_locked)
    else $error("sleep during program or erase did not lock");
  a_inhibit_tracks: assert property (
    intr_inhibit_o == (pe || boot_running_i))
    else $error("interrupt inhibit wrong");
  a_irq_held_off: assert property (intr_inhibit_o |-> !irq_o)
    else $error("interrupt while inhibited");
  a_hw_abort: assert property (hw |=> !pe && !flash_fault_flag_o)
    else $error("hardware protection did not abort");
  a_fault_sticky: assert property (
    flash_fault_flag_o && !hw |=> flash_fault_flag_o)
    else $error("fault flag dropped");
  a_no_reentry: assert property (flash_fault_flag_o |-> !pe)
    else $error("program or erase under error protection");
  a_block_gate: assert property (
    !erase_mode_o |-> erase_block_en_o == '0)
    else $error("block enabled outside erase");
  a_fault_cause: assert property (
    $rose(flash_fault_flag_o) |-> $past(pe))
    else $error("fault raised outside program or erase");
endmodule : flash_prot_checker
bind flash_prot_ctrl flash_prot_checker #(.NUM_BLOCKS(NUM_BLOCKS)) chk (
  .clock_i(clock_i), .reset_i(reset_i), .subsleep_i(subsleep_i),
  .standby_i(standby_i), .boot_running_i(boot_running_i),
  .flash_read_hit_i(flash_read_hit_i), .exception_start_i(exception_start_i),
  .sleep_exec_i(sleep_exec_i), .program_mode_o(program_mode_o),
  .erase_mode_o(erase_mode_o), .erase_block_en_o(erase_block_en_o),
  .intr_inhibit_o(intr_inhibit_o), .flash_fault_flag_o(flash_fault_flag_o),
  .irq_o(irq_o));
`default_nettype wire

// ==== tb/cpu_activity_model.sv ====
/* Model of the CPU activity seen by the protection block: flash reads,
   exception starts, sleep, power modes and boot, index 0 to 5.
   Assumes it is told by the bench when to act. */
`timescale 1ns/100ps
`default_nettype none
module cpu_activity_model (
  // Clock
  input wire logic clock_i,
  // Activity towards the block
  output logic flash_read_hit_o,
  output logic exception_start_o,
  output logic sleep_exec_o,
  output logic subsleep_o,
  output logic standby_o,
  output logic boot_running_o
);
  logic [5:0] act_ff = 6'h00;
  assign flash_read_hit_o = act_ff[0];
  assign exception_start_o = act_ff[1];
  assign sleep_exec_o = act_ff[2];
  assign subsleep_o = act_ff[3];
  assign standby_o = act_ff[4];
  assign boot_running_o = act_ff[5];
  // One-cycle event, as the CPU raises it for a single access
  task automatic pulse(input int k);
    @(posedge clock_i);
    act_ff[k] <= 1'b1;
    @(posedge clock_i);
    act_ff[k] <= 1'b0;
  endtask : pulse
  task automatic set_level(input int k, input logic v);
    @(posedge clock_i);
    act_ff[k] <= v;
  endtask : set_level
endmodule : cpu_activity_model
`default_nettype wire

// ==== tb/flash_program_erase_protection_bench.sv ====
/* Self-checking bench for the flash protection controller.
   Assumes the controller answers each bus access with waitrequest. */
`timescale 1ns/100ps
`default_nettype none
module flash_program_erase_protection_bench
  import flash_prot_pkg::*;
;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic rd_req = 1'b0;
  logic wr_req = 1'b0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] q;
  logic waitreq, hit, exc, slp, sub, stby, boot;
  logic pm, em, wm, vm, inh, fault, irq;
  logic [7:0] blk;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  always #5 clock_i = ~clock_i;
  cpu_activity_model cpu (.clock_i(clock_i), .flash_read_hit_o(hit),
    .exception_start_o(exc), .sleep_exec_o(slp), .subsleep_o(sub),
    .standby_o(stby), .boot_running_o(boot));
  flash_prot_ctrl #(.NUM_BLOCKS(8)) DUT (.clock_i(clock_i),
    .reset_i(reset_i), .avs_address_i(addr), .avs_read_i(rd_req),
    .avs_write_i(wr_req), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .subsleep_i(sub),
    .standby_i(stby), .boot_running_i(boot), .flash_read_hit_i(hit),
    .exception_start_i(exc), .sleep_exec_i(slp), .program_mode_o(pm),
    .erase_mode_o(em), .write_check_mode_o(wm), .wash_check_mode_o(vm),
    .erase_block_en_o(blk), .intr_inhibit_o(inh),
    .flash_fault_flag_o(fault), .irq_o(irq));
  task automatic summarize;
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask : chk
  // Waitrequest and read data are taken as they stand at the rising edge;
  // a slave that never answers is left to the cycle ceiling
  task automatic xfer(input logic w, input logic [4:0] a,
    input logic [7:0] d);
    @(posedge clock_i);
    addr <= a;
    wr_req <= w;
    rd_req <= !w;
    wdata <= {24'h0, d};
    do begin
      @(posedge clock_i);
    end while (waitreq !== 1'b0);
    q = rdata;
    wr_req <= 1'b0;
    rd_req <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic settle;
    repeat (3) @(negedge clock_i);
  endtask : settle
  initial begin
    repeat (3) @(posedge clock_i);
    reset_i <= 1'b0;
    xfer(1'b0, OFS_MODE_CTRL, 8'h00);
    chk("mode_ctrl", {24'h0, MODE_CTRL_RST}, q);
    xfer(1'b0, OFS_ERASE_SEL, 8'h00);
    chk("erase_sel", {24'h0, ERASE_SEL_RST}, q);
    xfer(1'b0, 5'h18, 8'h00);
    chk("unmapped", 32'h0, q);
    wr(OFS_IRQ_MASK, 8'h07);
    for (int i = 0; i < 2; i++) begin
      wr(OFS_MODE_CTRL, 8'h01 << i);
      settle();
      chk("pe_locked", 32'h0, {30'h0, em, pm});
    end
    xfer(1'b0, OFS_IRQ_STATUS, 8'h00);
    chk("irq_status", 32'h1 << EVT_REFUSED, q);
    chk("irq_high", 32'h1, {31'h0, irq});
    wr(OFS_IRQ_STATUS, 8'h07);
    settle();
    chk("irq_clear", 32'h0, {31'h0, irq});
    wr(OFS_ERASE_SEL, 8'h04);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_MODE_CTRL, 8'h40 | (8'h01 << i));
      settle();
      chk("mode", 32'h1 << i, {28'h0, vm, wm, em, pm});
      chk("inhibit", {31'h0, i < 2}, {31'h0, inh});
      chk("blocks", (i == 1) ? 32'h4 : 32'h0, {24'h0, blk});
    end
    wr(OFS_MODE_CTRL, 8'h42);
    wr(OFS_ERASE_SEL, 8'h00);
    settle();
    chk("no_block", 32'h0, {24'h0, blk});
    wr(OFS_MODE_CTRL, 8'h40);
    cpu.pulse(0);
    settle();
    chk("idle_hit", 32'h0, {31'h0, fault});
    for (int k = 0; k < 3; k++) begin
      cpu.set_level(3, 1'b1);
      cpu.set_level(3, 1'b0);
      wr(OFS_MODE_CTRL, 8'h41);
      settle();
      cpu.pulse(k);
      settle();
      chk("fault", 32'h1, {31'h0, fault});
      chk("aborted", 32'h0, {31'h0, pm});
      chk("irq_fault", 32'h1, {31'h0, irq});
      xfer(1'b0, OFS_MODE_CTRL, 8'h00);
      chk("kept", 32'h41, q);
      wr(OFS_MODE_CTRL, 8'h41);
      settle();
      chk("reentry", 32'h0, {31'h0, pm});
      wr(OFS_MODE_CTRL, 8'h44);
      settle();
      chk("verify", 32'h1, {31'h0, wm});
      xfer(1'b0, OFS_MODE_STATE, 8'h00);
      chk("mode_state", (32'h1 << ST_WRITE_CHECK) | (32'h1 << ST_ERR_PROT), q);
      wr(OFS_ERR_STATUS, 8'h00);
      xfer(1'b0, OFS_ERR_STATUS, 8'h00);
      chk("sticky", 32'h80 | (32'h1 << k), q);
    end
    cpu.set_level(3, 1'b1);
    cpu.set_level(3, 1'b0);
    wr(OFS_ERASE_SEL, 8'h01);
    wr(OFS_MODE_CTRL, 8'h42);
    settle();
    chk("erasing", 32'h1, {24'h0, blk});
    cpu.set_level(4, 1'b1);
    settle();
    chk("hw_abort", 32'h0, {30'h0, em, pm});
    xfer(1'b0, OFS_MODE_CTRL, 8'h00);
    chk("hw_mode", 32'h0, q);
    xfer(1'b0, OFS_ERASE_SEL, 8'h00);
    chk("hw_sel", 32'h0, q);
    xfer(1'b0, OFS_IRQ_STATUS, 8'h00);
    chk("irq_events", 32'h7, q);
    cpu.set_level(4, 1'b0);
    cpu.set_level(5, 1'b1);
    settle();
    chk("boot_inhibit", 32'h1, {31'h0, inh});
    summarize();
  end
endmodule : flash_program_erase_protection_bench
`default_nettype wire
